/* rtl/cflb_bank.sv */
`default_nettype none
module cflb_bank (
  input  wire logic                           i_mclk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_psel,
  input  wire logic                           i_penable,
  input  wire logic                           i_pwrite,
  input  wire logic [cflb_pkg::ADDR_W-1:0]    i_paddr,
  input  wire logic [cflb_pkg::DATA_W-1:0]    i_pwdata,
  output logic      [cflb_pkg::DATA_W-1:0]    o_prdata,
  output logic                                o_pready,
  output logic                                o_pslverr,
  input  wire logic                           i_unit_clk,
  input  wire logic                           i_clk_en,
  input  wire logic                           i_alternate_write_clk_enable,
  input  wire logic                           i_local_set_reset,
  input  wire logic                           i_front_sel,
  input  wire logic                           i_global_set_reset_n,
  input  wire logic [cflb_pkg::NUM_GEN-1:0]   i_lut_out,
  input  wire logic [cflb_pkg::NUM_GEN-1:0]   i_din,
  input  wire logic                           i_carry_input,
  input  wire logic                           i_carry_out,
  output logic      [cflb_pkg::NUM_EL-1:0]    o_q
);
  logic [cflb_pkg::COMMON_W-1:0] common_reg;
  logic [cflb_pkg::GROUP_W-1:0]  group_reg;
  logic [cflb_pkg::MODE_W-1:0]   mode_reg;
  logic [cflb_pkg::SRC_W-1:0]    src_reg;
  logic [cflb_pkg::NUM_EL-1:0]   srval_reg;
  logic [cflb_pkg::NUM_EL-1:0]   q_reg;
  logic [cflb_pkg::NUM_EL-1:0]   q_next;
  logic                          uclk_prev_reg;
  logic [cflb_pkg::DATA_W-1:0]   rdata_next;
  logic                          err_next;

  // ---------------- APB slave ----------------
  wire apb_acc   = i_psel & i_penable;
  wire apb_done  = apb_acc & o_pready;
  wire apb_wr    = apb_done & i_pwrite;
  wire hit_com   = (i_paddr == cflb_pkg::ADDR_COMMON);
  wire hit_grp   = (i_paddr == cflb_pkg::ADDR_GROUP);
  wire hit_mode  = (i_paddr == cflb_pkg::ADDR_MODE);
  wire hit_src   = (i_paddr == cflb_pkg::ADDR_SRC);
  wire hit_srv   = (i_paddr == cflb_pkg::ADDR_SRVAL);
  wire hit_stat  = (i_paddr == cflb_pkg::ADDR_STATUS);

  always_comb begin
    rdata_next = '0;
    err_next   = 1'b0;
    if (hit_com) begin
      rdata_next[cflb_pkg::COMMON_W-1:0] = common_reg;
    end else if (hit_grp) begin
      rdata_next[cflb_pkg::GROUP_W-1:0] = group_reg;
    end else if (hit_mode) begin
      rdata_next[cflb_pkg::MODE_W-1:0] = mode_reg;
    end else if (hit_src) begin
      rdata_next[cflb_pkg::SRC_W-1:0] = src_reg;
    end else if (hit_srv) begin
      rdata_next[cflb_pkg::NUM_EL-1:0] = srval_reg;
    end else if (hit_stat) begin
      rdata_next[cflb_pkg::NUM_EL-1:0] = q_reg;
    end else begin
      err_next = 1'b1;
    end
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= apb_acc & ~o_pready;
      o_prdata  <= rdata_next;
      o_pslverr <= apb_acc & ~o_pready & err_next;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      common_reg <= cflb_pkg::RST_COMMON;
      group_reg  <= cflb_pkg::RST_GROUP;
      mode_reg   <= cflb_pkg::RST_MODE;
      src_reg    <= cflb_pkg::RST_SRC;
      srval_reg  <= cflb_pkg::RST_SRVAL;
    end else if (apb_wr) begin
      if (hit_com) begin
        common_reg <= i_pwdata[cflb_pkg::COMMON_W-1:0];
      end else if (hit_grp) begin
        group_reg <= i_pwdata[cflb_pkg::GROUP_W-1:0];
      end else if (hit_mode) begin
        mode_reg <= i_pwdata[cflb_pkg::MODE_W-1:0];
      end else if (hit_src) begin
        src_reg <= i_pwdata[cflb_pkg::SRC_W-1:0];
      end else if (hit_srv) begin
        srval_reg <= i_pwdata[cflb_pkg::NUM_EL-1:0];
      end
    end
  end

  // ---------------- shared controls ----------------
  wire lsr_async = common_reg[cflb_pkg::C_LSR_ASYNC];
  wire lsr_over  = common_reg[cflb_pkg::C_LSR_OVER];
  wire fe_mode   = common_reg[cflb_pkg::C_FE_MODE];
  wire clk_eff   = i_unit_clk ^ common_reg[cflb_pkg::C_CLK_INV];
  wire ce_eff    = i_clk_en ^ common_reg[cflb_pkg::C_CE_INV];
  wire lsr_eff   = i_local_set_reset ^ common_reg[cflb_pkg::C_LSR_INV];
  wire sel_eff   = i_front_sel ^ common_reg[cflb_pkg::C_SEL_INV];
  wire gsr_act   = ~i_global_set_reset_n & common_reg[cflb_pkg::C_GSR_EN];
  wire clk_rise  = clk_eff & ~uclk_prev_reg;
  wire clk_fall  = ~clk_eff & uclk_prev_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      uclk_prev_reg <= 1'b0;
      q_reg         <= '0;
    end else begin
      uclk_prev_reg <= clk_eff;
      q_reg         <= q_next;
    end
  end
  assign o_q = q_reg;

  // per-group enable and local set/reset use
  logic [cflb_pkg::NUM_GRP-1:0] grp_ce;
  logic [cflb_pkg::NUM_GRP-1:0] grp_lsr;
  genvar gg;
  generate
    for (gg = 0; gg < cflb_pkg::NUM_GRP; gg++) begin : g_grp
      wire [1:0] ce_src = group_reg[gg*cflb_pkg::GRP_W+cflb_pkg::G_CE_LSB +: 2];
      assign grp_ce[gg]  = (ce_src == cflb_pkg::CE_PRI) ? ce_eff :
                           (ce_src == cflb_pkg::CE_ALT) ? i_alternate_write_clk_enable : 1'b1;
      assign grp_lsr[gg] = group_reg[gg*cflb_pkg::GRP_W+cflb_pkg::G_LSR] & lsr_eff;
    end
  endgenerate

  // ---------------- storage elements ----------------
  logic [cflb_pkg::NUM_EL-1:0] el_d;
  logic [cflb_pkg::NUM_EL-1:0] el_edge;
  logic [cflb_pkg::NUM_EL-1:0] el_open;
  logic [cflb_pkg::NUM_EL-1:0] el_ce;
  logic [cflb_pkg::NUM_EL-1:0] el_lsr;
  genvar gi;
  generate
    for (gi = 0; gi < cflb_pkg::NUM_EL; gi++) begin : g_el
      localparam int GRP = gi / 4;
      wire [1:0] src = src_reg[2*gi +: 2];
      if (gi < cflb_pkg::NUM_GEN) begin : g_gen
        wire [1:0] md = mode_reg[2*gi +: 2];
        wire       d_src = (src == cflb_pkg::SRC_ONE) ? 1'b1 :
                           (src == cflb_pkg::SRC_A)   ? i_lut_out[gi] :
                           (src == cflb_pkg::SRC_B)   ? i_din[gi] : 1'b0;
        assign el_d[gi]    = fe_mode ? (sel_eff ? i_din[gi] : i_lut_out[gi]) : d_src;
        assign el_edge[gi] = (md == cflb_pkg::MD_FF_RISE) ? clk_rise :
                             (md == cflb_pkg::MD_FF_FALL) ? clk_fall : 1'b0;
        assign el_open[gi] = (md == cflb_pkg::MD_LATCH_POS) ? clk_eff :
                             (md == cflb_pkg::MD_LATCH_NEG) ? ~clk_eff : 1'b0;
      end else begin : g_ninth
        assign el_d[gi]    = (src == cflb_pkg::SRC_ONE) ? 1'b1 :
                             (src == cflb_pkg::SRC_A)   ? i_carry_input :
                             (src == cflb_pkg::SRC_B)   ? i_carry_out : 1'b0;
        assign el_edge[gi] = clk_rise;
        assign el_open[gi] = 1'b0;
      end
      assign el_ce[gi]  = grp_ce[GRP];
      assign el_lsr[gi] = grp_lsr[GRP];
      // priority: global, asynchronous local, latch, clocked flop
      assign q_next[gi] = gsr_act                 ? srval_reg[gi] :
                          (el_lsr[gi] & lsr_async) ? srval_reg[gi] :
                          el_open[gi]              ? (el_lsr[gi] ? srval_reg[gi] : el_d[gi]) :
                          ~el_edge[gi]             ? q_reg[gi] :
                          (el_lsr[gi] & (lsr_over | el_ce[gi])) ? srval_reg[gi] :
                          el_ce[gi]                ? el_d[gi] : q_reg[gi];
    end
  endgenerate

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  wire quiet0 = ~gsr_act & ~el_lsr[0];
  wire quiet8 = ~gsr_act & ~el_lsr[8];
  wire quiet4 = ~gsr_act & ~el_lsr[4];

  property p_gsr_force;
    ~i_global_set_reset_n & common_reg[cflb_pkg::C_GSR_EN] |=> q_reg == $past(srval_reg);
  endproperty
  a_gsr_force: assert property (p_gsr_force) else $error("global set/reset did not force value");

  property p_gsr_wins;
    gsr_act & el_lsr[0] & ~srval_reg[0] ##0 el_d[0] |=> ~q_reg[0];
  endproperty
  a_gsr_wins: assert property (p_gsr_wins) else $error("global set/reset lost priority");

  property p_gsr_off;
    ~common_reg[cflb_pkg::C_GSR_EN] & ~i_global_set_reset_n & ~el_lsr[8] & ~el_edge[8] |=> $stable(q_reg[8]);
  endproperty
  a_gsr_off: assert property (p_gsr_off) else $error("disabled global set/reset had effect");

  property p_async_lsr;
    ~gsr_act & lsr_async & el_lsr[0] |=> q_reg[0] == $past(srval_reg[0]);
  endproperty
  a_async_lsr: assert property (p_async_lsr) else $error("asynchronous local set/reset missed");

  property p_ce_hold;
    quiet0 & el_edge[0] & ~el_ce[0] |=> q_reg[0] == $past(q_reg[0]);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("flop changed with enable inactive");

  property p_lsr_over;
    ~gsr_act & ~lsr_async & lsr_over & el_lsr[8] & el_edge[8] |=> q_reg[8] == $past(srval_reg[8]);
  endproperty
  a_lsr_over: assert property (p_lsr_over) else $error("overriding local set/reset missed");

  property p_lsr_gated;
    ~gsr_act & ~lsr_async & ~lsr_over & el_lsr[8] & el_edge[8] & ~el_ce[8] |=> $stable(q_reg[8]);
  endproperty
  a_lsr_gated: assert property (p_lsr_gated) else $error("gated local set/reset acted without enable");

  property p_latch_no_ce;
    quiet0 & el_open[0] & ~el_ce[0] |=> q_reg[0] == $past(el_d[0]);
  endproperty
  a_latch_no_ce: assert property (p_latch_no_ce) else $error("latch blocked by clock enable");

  property p_front_sel;
    quiet0 & fe_mode & sel_eff & el_edge[0] & el_ce[0] |=> q_reg[0] == $past(i_din[0]);
  endproperty
  a_front_sel: assert property (p_front_sel) else $error("front-end select picked wrong input");

  property p_ninth_carry;
    quiet8 & (src_reg[17:16] == cflb_pkg::SRC_A) & el_edge[8] & el_ce[8] |=> q_reg[8] == $past(i_carry_input);
  endproperty
  a_ninth_carry: assert property (p_ninth_carry) else $error("ninth flop missed carry input");

  property p_const_zero;
    quiet0 & ~fe_mode & (src_reg[1:0] == cflb_pkg::SRC_ZERO) & (el_edge[0] & el_ce[0] | el_open[0]) |=> ~q_reg[0];
  endproperty
  a_const_zero: assert property (p_const_zero) else $error("default constant zero not taken");

  property p_idle_hold;
    quiet0 & ~el_edge[0] & ~el_open[0] ##1 quiet0 & ~el_edge[0] & ~el_open[0] |=> $stable(q_reg[0]);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("flop moved without a clock edge");

  property p_ready_wait;
    i_psel & i_penable & ~o_pready |=> o_pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready missing after wait state");

  property p_ready_pulse;
    o_pready |=> ~o_pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held longer than one cycle");

  property p_err_unmapped;
    i_psel & i_penable & ~o_pready & err_next |=> o_pslverr & (o_prdata == '0);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not flagged");

  property p_err_mapped;
    i_psel & i_penable & ~o_pready & ~err_next |=> ~o_pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access flagged as error");

  property p_common_write;
    apb_wr & hit_com |=> common_reg == $past(i_pwdata[cflb_pkg::COMMON_W-1:0]);
  endproperty
  a_common_write: assert property (p_common_write) else $error("common write did not land");

  property p_srval_write;
    apb_wr & hit_srv |=> srval_reg == $past(i_pwdata[cflb_pkg::NUM_EL-1:0]);
  endproperty
  a_srval_write: assert property (p_srval_write) else $error("set/reset value write lost");

  property p_fall_ff;
    quiet0 & (g_el[0].g_gen.md == cflb_pkg::MD_FF_FALL) & el_edge[0] & el_ce[0] |=> q_reg[0] == $past(el_d[0]);
  endproperty
  a_fall_ff: assert property (p_fall_ff) else $error("falling flop missed its edge");

  property p_rise_skip_fall;
    quiet0 & (g_el[0].g_gen.md == cflb_pkg::MD_FF_RISE) & clk_fall |=> q_reg[0] == $past(q_reg[0]);
  endproperty
  a_rise_skip_fall: assert property (p_rise_skip_fall) else $error("rising flop moved on fall");

  property p_ninth_rise_only;
    quiet8 & clk_fall |=> q_reg[8] == $past(q_reg[8]);
  endproperty
  a_ninth_rise_only: assert property (p_ninth_rise_only) else $error("ninth flop moved on fall");

  property p_alt_hold;
    quiet4 & el_edge[4] & (g_grp[1].ce_src == cflb_pkg::CE_ALT) & ~i_alternate_write_clk_enable
      |=> $stable(q_reg[4]);
  endproperty
  a_alt_hold: assert property (p_alt_hold) else $error("alternate enable did not hold");

  property p_ninth_none;
    quiet8 & el_edge[8] & (g_grp[2].ce_src != cflb_pkg::CE_PRI) & (g_grp[2].ce_src != cflb_pkg::CE_ALT)
      |=> q_reg[8] == $past(el_d[8]);
  endproperty
  a_ninth_none: assert property (p_ninth_none) else $error("ninth flop without enable missed data");

  c_gsr:   cover property (gsr_act ##1 ~gsr_act);
  c_latch: cover property (el_open[0] ##1 ~el_open[0]);
  c_ninth: cover property (el_edge[8] & el_ce[8] & quiet8);
  c_fe:    cover property (fe_mode & el_edge[0] & el_ce[0]);
  c_fall:  cover property (el_edge[0] & el_ce[0] & (g_el[0].g_gen.md == cflb_pkg::MD_FF_FALL));
endmodule
`default_nettype wire

/* rtl/cflb_pkg.sv */
`default_nettype none
package cflb_pkg;
  localparam int NUM_EL  = 9;
  localparam int NUM_GEN = 8;
  localparam int NUM_GRP = 3;
  localparam int GRP_W   = 3;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;

  // register byte addresses
  localparam logic [7:0] ADDR_COMMON = 8'h00;
  localparam logic [7:0] ADDR_GROUP  = 8'h04;
  localparam logic [7:0] ADDR_MODE   = 8'h08;
  localparam logic [7:0] ADDR_SRC    = 8'h0c;
  localparam logic [7:0] ADDR_SRVAL  = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // common register bit positions
  localparam int C_LSR_ASYNC = 0;
  localparam int C_CLK_INV   = 1;
  localparam int C_SEL_INV   = 2;
  localparam int C_CE_INV    = 3;
  localparam int C_LSR_INV   = 4;
  localparam int C_LSR_OVER  = 5;
  localparam int C_GSR_EN    = 6;
  localparam int C_FE_MODE   = 7;
  localparam int COMMON_W    = 8;

  // group field: [1:0] enable source, [2] local set/reset used
  localparam int G_CE_LSB = 0;
  localparam int G_LSR    = 2;
  localparam int GROUP_W  = NUM_GRP * GRP_W;
  localparam int MODE_W   = 2 * NUM_GEN;
  localparam int SRC_W    = 2 * NUM_EL;

  localparam logic [COMMON_W-1:0] RST_COMMON = 8'h40;
  localparam logic [GROUP_W-1:0]  RST_GROUP  = 9'h000;
  localparam logic [MODE_W-1:0]   RST_MODE   = 16'haaaa;
  localparam logic [SRC_W-1:0]    RST_SRC    = 18'h00000;
  localparam logic [NUM_EL-1:0]   RST_SRVAL  = 9'h000;

  localparam logic [1:0] CE_NONE = 2'h0;
  localparam logic [1:0] CE_PRI  = 2'h1;
  localparam logic [1:0] CE_ALT  = 2'h2;

  localparam logic [1:0] MD_LATCH_POS = 2'h0;
  localparam logic [1:0] MD_LATCH_NEG = 2'h1;
  localparam logic [1:0] MD_FF_RISE   = 2'h2;
  localparam logic [1:0] MD_FF_FALL   = 2'h3;

  // source: 0 zero, 1 one, 2 lut (ninth: carry input), 3 direct (ninth: carry-out)
  localparam logic [1:0] SRC_ZERO = 2'h0;
  localparam logic [1:0] SRC_ONE  = 2'h1;
  localparam logic [1:0] SRC_A    = 2'h2;
  localparam logic [1:0] SRC_B    = 2'h3;
endpackage
`default_nettype wire

/* rtl/cflb_dummy_removed.sv */
`default_nettype none
`default_nettype wire

/* tb/cflb_lut_model.sv */
`default_nettype none
module cflb_lut_model (
  input  wire logic [7:0] i_op_a,
  input  wire logic [7:0] i_op_b,
  input  wire logic       i_carry_input,
  output logic      [7:0] o_lut_out,
  output logic            o_carry_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // each lookup table forms one sum bit of a ripple adder; the last carry leaves the unit
  assign {o_carry_out, o_lut_out} = {1'b0, i_op_a} + {1'b0, i_op_b} + {8'h00, i_carry_input};
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic        pready, pslverr, rde, cout;
  logic        ucl = 1'b0, ce = 1'b1, alt = 1'b0, local_set_reset = 1'b0, sel = 1'b0, gsr_n = 1'b1, carry_input = 1'b0;
  logic [7:0]  op_a = 8'h00, op_b = 8'h00, din = 8'h00, lut;
  logic [8:0]  q;
  int          n_errors = 0, comparisons = 0;

  always #12.5 mclk = ~mclk;

  cflb_lut_model lut_model (.i_op_a(op_a), .i_op_b(op_b), .i_carry_input(carry_input), .o_lut_out(lut), .o_carry_out(cout));

  cflb_bank dut (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_unit_clk(ucl), .i_clk_en(ce), .i_alternate_write_clk_enable(alt), .i_local_set_reset(local_set_reset),
    .i_front_sel(sel), .i_global_set_reset_n(gsr_n), .i_lut_out(lut), .i_din(din),
    .i_carry_input(carry_input), .i_carry_out(cout), .o_q(q)
  );

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input logic eexp);
    apb(1'b0, ad, 32'h0);
    chk("prdata", rdv, exp);
    chk("pslverr", {31'h0, rde}, {31'h0, eexp});
  endtask

  // move the unit clock, then give the bank time to react
  task automatic uc(input logic v);
    @(posedge mclk);
    ucl <= v;
    repeat (3) @(posedge mclk);
  endtask

  task automatic pl();
    uc(1'b0);
    uc(1'b1);
  endtask

  task automatic dat(input logic [7:0] a, input logic [7:0] b, input logic c, input logic [7:0] d);
    @(posedge mclk);
    op_a <= a;
    op_b <= b;
    carry_input <= c;
    din <= d;
  endtask

  task automatic qc(input logic [8:0] exp);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("q", {23'h0, q}, {23'h0, exp});
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(cflb_pkg::ADDR_COMMON, {24'h0, cflb_pkg::RST_COMMON}, 1'b0);
    rd(cflb_pkg::ADDR_GROUP, {23'h0, cflb_pkg::RST_GROUP}, 1'b0);
    rd(cflb_pkg::ADDR_MODE, {16'h0, cflb_pkg::RST_MODE}, 1'b0);
    rd(cflb_pkg::ADDR_SRC, {14'h0, cflb_pkg::RST_SRC}, 1'b0);
    rd(cflb_pkg::ADDR_SRVAL, {23'h0, cflb_pkg::RST_SRVAL}, 1'b0);
    wr(cflb_pkg::ADDR_STATUS, 32'hffff_ffff);
    rd(cflb_pkg::ADDR_STATUS, 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    wr(cflb_pkg::ADDR_GROUP, 32'h0000_016d);
    rd(cflb_pkg::ADDR_GROUP, 32'h0000_016d, 1'b0);
    wr(cflb_pkg::ADDR_SRC, 32'h0002_aaaa);
    wr(cflb_pkg::ADDR_SRVAL, 32'h0000_00f0);
    dat(8'h3c, 8'h35, 1'b1, 8'h00);
    uc(1'b1);
    qc(9'h172);
    dat(8'h0f, 8'h00, 1'b0, 8'h00);
    @(posedge mclk) ce <= 1'b0;
    pl();
    qc(9'h172);
    @(posedge mclk) local_set_reset <= 1'b1;
    pl();
    qc(9'h172);
    wr(cflb_pkg::ADDR_COMMON, 32'h0000_0060);
    pl();
    qc(9'h0f0);
    @(posedge mclk) local_set_reset <= 1'b0;
    @(posedge mclk) ce <= 1'b1;
    pl();
    qc(9'h00f);
    wr(cflb_pkg::ADDR_COMMON, 32'h0000_0041);
    @(posedge mclk) local_set_reset <= 1'b1;
    qc(9'h0f0);
    @(posedge mclk) local_set_reset <= 1'b0;
    dat(8'h55, 8'h00, 1'b0, 8'h00);
    pl();
    qc(9'h055);
    @(posedge mclk) gsr_n <= 1'b0;
    qc(9'h0f0);
    @(posedge mclk) local_set_reset <= 1'b1;
    pl();
    qc(9'h0f0);
    @(posedge mclk) local_set_reset <= 1'b0;
    @(posedge mclk) gsr_n <= 1'b1;
    pl();
    qc(9'h055);
    wr(cflb_pkg::ADDR_COMMON, 32'h0000_0000);
    @(posedge mclk) gsr_n <= 1'b0;
    qc(9'h055);
    @(posedge mclk) gsr_n <= 1'b1;
    wr(cflb_pkg::ADDR_COMMON, 32'h0000_0080);
    dat(8'h55, 8'h00, 1'b0, 8'ha5);
    @(posedge mclk) sel <= 1'b1;
    pl();
    qc(9'h0a5);
    @(posedge mclk) sel <= 1'b0;
    pl();
    qc(9'h055);
    wr(cflb_pkg::ADDR_COMMON, 32'h0000_008c);
    @(posedge mclk) ce <= 1'b0;
    pl();
    qc(9'h0a5);
    wr(cflb_pkg::ADDR_COMMON, 32'h0000_0040);
    @(posedge mclk) ce <= 1'b1;
    wr(cflb_pkg::ADDR_SRC, 32'h0003_55e4);
    dat(8'hff, 8'h01, 1'b0, 8'h0f);
    pl();
    qc(9'h1fa);
    wr(cflb_pkg::ADDR_SRC, 32'h0002_aaaa);
    wr(cflb_pkg::ADDR_GROUP, 32'h0000_00d1);
    dat(8'h33, 8'h00, 1'b1, 8'h0f);
    pl();
    qc(9'h1f4);
    dat(8'h5a, 8'h00, 1'b0, 8'h0f);
    @(posedge mclk) alt <= 1'b1;
    @(posedge mclk) ce <= 1'b0;
    pl();
    qc(9'h054);
    wr(cflb_pkg::ADDR_GROUP, 32'h0000_00d5);
    wr(cflb_pkg::ADDR_COMMON, 32'h0000_0041);
    @(posedge mclk) local_set_reset <= 1'b1;
    qc(9'h050);
    @(posedge mclk) local_set_reset <= 1'b0;
    wr(cflb_pkg::ADDR_COMMON, 32'h0000_0040);
    dat(8'hcc, 8'h00, 1'b0, 8'h0f);
    wr(cflb_pkg::ADDR_MODE, 32'h0000_5500);
    qc(9'h05c);
    uc(1'b0);
    qc(9'h0cc);
    dat(8'h00, 8'h00, 1'b0, 8'h0f);
    qc(9'h00c);
    wr(cflb_pkg::ADDR_MODE, 32'h0000_aaaa);
    uc(1'b1);
    wr(cflb_pkg::ADDR_COMMON, 32'h0000_0042);
    @(posedge mclk) ce <= 1'b1;
    dat(8'h99, 8'h00, 1'b1, 8'h0f);
    uc(1'b0);
    qc(9'h19a);
    dat(8'h11, 8'h00, 1'b0, 8'h0f);
    uc(1'b1);
    qc(9'h19a);
    wr(cflb_pkg::ADDR_MODE, 32'h0000_ffff);
    uc(1'b0);
    qc(9'h09a);
    uc(1'b1);
    qc(9'h011);
    wr(cflb_pkg::ADDR_COMMON, 32'h0000_0053);
    qc(9'h010);
    @(posedge mclk) local_set_reset <= 1'b1;
    pl();
    qc(9'h011);
    summarize();
  end
endmodule
`default_nettype wire
